// ===== common/scfc_pkg.sv
// Shared constants, types and helpers for the serial clock and frame core
package scfc_pkg;

	localparam int DIV_W = 12;
	localparam logic [11:0] DIVISOR_RESET = 12'h000;

	// Baud ticks per bit: 16 normal, 8 double speed; synchronous uses two clock phases
	localparam logic [3:0] LAST_PHASE_NORMAL = 4'hf;
	localparam logic [3:0] LAST_PHASE_DOUBLE = 4'h7;
	localparam logic [3:0] HALF_PHASE_NORMAL = 4'h8;
	localparam logic [3:0] HALF_PHASE_DOUBLE = 4'h4;
	localparam logic [3:0] PHASE_FIRST = 4'h1;

	localparam logic [2:0] CSIZE_5 = 3'h0;
	localparam logic [2:0] CSIZE_6 = 3'h1;
	localparam logic [2:0] CSIZE_7 = 3'h2;
	localparam logic [2:0] CSIZE_8 = 3'h3;
	localparam logic [2:0] CSIZE_9 = 3'h7;

	localparam logic [1:0] PARITY_OFF = 2'h0;
	localparam logic [1:0] PARITY_EVEN = 2'h2;
	localparam logic [1:0] PARITY_ODD = 2'h3;

	localparam logic [8:0] TX_BUF_RESET = 9'h000;
	localparam logic [8:0] RX_DATA_RESET = 9'h000;

	typedef enum logic [2:0] {SCFC_IDLE, SCFC_START, SCFC_DATA, SCFC_PARITY, SCFC_STOP} scfc_frame_t;

	function automatic logic [3:0] scfc_data_bits(input logic [2:0] size);
		case (size)
			CSIZE_5: return 4'h5;
			CSIZE_6: return 4'h6;
			CSIZE_7: return 4'h7;
			CSIZE_8: return 4'h8;
			CSIZE_9: return 4'h9;
			default: return 4'h8;
		endcase
	endfunction : scfc_data_bits

	function automatic logic scfc_parity(input logic [8:0] data, input logic [3:0] nbits,
			input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(nbits)) begin
				p = p ^ data[i];
			end
		end
		return p;
	endfunction : scfc_parity

endpackage : scfc_pkg

// ===== rtl/scfc_baud_gen.sv
// Programmable down-counter producing the baud tick
`timescale 1ns/100ps
`default_nettype none
module scfc_baud_gen
	import scfc_pkg::*;
#(
	parameter int DivW = DIV_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Divisor and reload strobe
	input wire logic [DivW-1:0] divisor,
	input wire logic reload,
	// Tick
	output logic tick
);

	logic [DivW-1:0] count_q;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count_q <= '0;
			tick <= 1'b0;
		end else if (reload) begin
			count_q <= divisor;
			tick <= 1'b0;
		end else if (count_q == '0) begin
			count_q <= divisor;
			tick <= 1'b1;
		end else begin
			count_q <= count_q - 1'b1;
			tick <= 1'b0;
		end
	end

endmodule : scfc_baud_gen
`default_nettype wire

// ===== rtl/scfc_edge_sync.sv
// Synchroniser and edge detector for the external transfer clock
`timescale 1ns/100ps
`default_nettype none
module scfc_edge_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Pin
	input wire logic pinIn,
	// Detected edges, one cycle each
	output logic rise,
	output logic fall
);

	logic sync1_q;
	logic sync2_q;
	logic prev_q;

	// Two clocks of latency from pin to edge pulse
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= pinIn;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign rise = sync2_q & ~prev_q;
	assign fall = ~sync2_q & prev_q;

endmodule : scfc_edge_sync
`default_nettype wire

// ===== rtl/scfc_core.sv
// Serial clock generation and frame formatting core
`timescale 1ns/100ps
`default_nettype none
module scfc_core
	import scfc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Baud divisor
	input wire logic [3:0] baudDivisorHigh,
	input wire logic [7:0] baudDivisorLow,
	input wire logic baudDivisorLowWrite,
	// Mode and frame format
	input wire logic doubleSpeedSelect,
	input wire logic syncSelect,
	input wire logic transferClockDirection,
	input wire logic clockPolaritySelect,
	input wire logic [2:0] characterSizeField,
	input wire logic [1:0] parityModeField,
	input wire logic stopCountSelect,
	// Transmit data
	input wire logic [7:0] txData,
	input wire logic transmitNinthBit,
	input wire logic txDataWrite,
	output logic txBufferEmpty,
	output logic transmitComplete,
	// Receive data
	output logic [8:0] rxData,
	output logic receiveComplete,
	output logic frameErrorFlag,
	output logic parityError,
	// Serial pins
	input wire logic rxd,
	output logic txd,
	input wire logic transferClockIn,
	output logic transferClockOut,
	output logic transferClockOe
);

	logic [1:0] rstPipe_q;
	logic rstN;
	logic baudTick;
	logic slaveRise;
	logic slaveFall;
	logic masterMode;
	logic slaveMode;
	logic doubleSpeed;
	logic xRise;
	logic xFall;
	logic changeEdge;
	logic sampleEdge;
	logic [3:0] lastPhase;
	logic [3:0] halfPhase;
	logic [3:0] nBits;
	logic parityOn;
	logic parityOdd;

	// Reset release is synchronised; assertion stays asynchronous
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstN = rstPipe_q[1];

	scfc_baud_gen #(
		.DivW(DIV_W)
	) u_baud (
		.clk(core_clk),
		.rstN(rstN),
		.divisor({baudDivisorHigh, baudDivisorLow}),
		.reload(baudDivisorLowWrite),
		.tick(baudTick)
	);

	scfc_edge_sync u_xsync (
		.clk(core_clk),
		.rstN(rstN),
		.pinIn(transferClockIn),
		.rise(slaveRise),
		.fall(slaveFall)
	);

	// Mode decode
	assign masterMode = syncSelect & transferClockDirection;
	assign slaveMode = syncSelect & ~transferClockDirection;
	assign doubleSpeed = doubleSpeedSelect & ~syncSelect;
	assign lastPhase = doubleSpeed ? LAST_PHASE_DOUBLE : LAST_PHASE_NORMAL;
	assign halfPhase = doubleSpeed ? HALF_PHASE_DOUBLE : HALF_PHASE_NORMAL;

	// One shared format for both directions
	assign nBits = scfc_data_bits(characterSizeField);
	assign parityOn = (parityModeField == PARITY_EVEN) || (parityModeField == PARITY_ODD);
	assign parityOdd = (parityModeField == PARITY_ODD);

	// Master clock toggles every tick, so one bit spans two ticks
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			transferClockOut <= 1'b0;
		end else if (masterMode && baudTick) begin
			transferClockOut <= ~transferClockOut;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			transferClockOe <= 1'b0;
		end else begin
			transferClockOe <= masterMode;
		end
	end

	// Slave edges come only from the pin, never from the local tick
	assign xRise = (masterMode & baudTick & ~transferClockOut) | (slaveMode & slaveRise);
	assign xFall = (masterMode & baudTick & transferClockOut) | (slaveMode & slaveFall);
	assign changeEdge = clockPolaritySelect ? xFall : xRise;
	assign sampleEdge = clockPolaritySelect ? xRise : xFall;

	// Transmitter
	logic [3:0] txPhase_q;
	logic txBitEn;
	logic [8:0] txBuf_q;
	logic txBufFull_q;
	logic txTake;
	scfc_frame_t txState_q;
	logic [8:0] txShift_q;
	logic [3:0] txCount_q;
	logic txStop2_q;
	logic txPar_q;
	logic txEnd;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			txPhase_q <= 4'h0;
		end else if (baudTick) begin
			txPhase_q <= (txPhase_q >= lastPhase) ? 4'h0 : txPhase_q + 4'h1;
		end
	end
	assign txBitEn = syncSelect ? changeEdge : (baudTick && txPhase_q == lastPhase);

	assign txEnd = txBitEn && txState_q == SCFC_STOP && txStop2_q == stopCountSelect;
	assign txTake = txBufFull_q && txBitEn && (txState_q == SCFC_IDLE || txEnd);

	// Single write buffer lets frames follow with no gap
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			txBuf_q <= TX_BUF_RESET;
			txBufFull_q <= 1'b0;
		end else if (txDataWrite && (!txBufFull_q || txTake)) begin
			txBuf_q <= {transmitNinthBit, txData};
			txBufFull_q <= 1'b1;
		end else if (txTake) begin
			txBufFull_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			txState_q <= SCFC_IDLE;
			txShift_q <= TX_BUF_RESET;
			txCount_q <= 4'h0;
			txStop2_q <= 1'b0;
			txPar_q <= 1'b0;
			txd <= 1'b1;
		end else if (txTake) begin
			txShift_q <= txBuf_q;
			txPar_q <= scfc_parity(txBuf_q, nBits, parityOdd);
			txd <= 1'b0;
			txState_q <= SCFC_START;
		end else if (txBitEn) begin
			case (txState_q)
				SCFC_IDLE: begin
					txd <= 1'b1;
				end
				SCFC_START: begin
					txd <= txShift_q[0];
					txShift_q <= {1'b0, txShift_q[8:1]};
					txCount_q <= 4'h1;
					txState_q <= SCFC_DATA;
				end
				SCFC_DATA: begin
					if (txCount_q == nBits) begin
						txd <= parityOn ? txPar_q : 1'b1;
						txState_q <= parityOn ? SCFC_PARITY : SCFC_STOP;
						txStop2_q <= 1'b0;
					end else begin
						txd <= txShift_q[0];
						txShift_q <= {1'b0, txShift_q[8:1]};
						txCount_q <= txCount_q + 4'h1;
					end
				end
				SCFC_PARITY: begin
					txd <= 1'b1;
					txStop2_q <= 1'b0;
					txState_q <= SCFC_STOP;
				end
				SCFC_STOP: begin
					txd <= 1'b1;
					if (txStop2_q == stopCountSelect) begin
						txState_q <= SCFC_IDLE;
					end else begin
						txStop2_q <= 1'b1;
					end
				end
				default: begin
					txd <= 1'b1;
					txState_q <= SCFC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			txBufferEmpty <= 1'b1;
			transmitComplete <= 1'b0;
		end else begin
			txBufferEmpty <= ~txBufFull_q;
			transmitComplete <= txEnd && !txBufFull_q;
		end
	end

	// Receiver
	scfc_frame_t rxState_q;
	logic [3:0] rxPhase_q;
	logic [3:0] rxCount_q;
	logic [8:0] rxShift_q;
	logic rxParBit_q;
	logic rxSampleEn;
	logic rxDetect;

	// Asynchronous start search looks at every tick; synchronous at each sample edge
	assign rxDetect = (rxState_q == SCFC_IDLE) && !rxd &&
		(syncSelect ? sampleEdge : baudTick);
	assign rxSampleEn = (rxState_q != SCFC_IDLE) &&
		(syncSelect ? sampleEdge : (baudTick && rxPhase_q == halfPhase));

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			rxPhase_q <= 4'h0;
		end else if (rxDetect) begin
			rxPhase_q <= PHASE_FIRST;
		end else if (baudTick && rxState_q != SCFC_IDLE) begin
			rxPhase_q <= (rxPhase_q >= lastPhase) ? 4'h0 : rxPhase_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			rxState_q <= SCFC_IDLE;
			rxCount_q <= 4'h0;
			rxShift_q <= RX_DATA_RESET;
			rxParBit_q <= 1'b0;
		end else if (rxDetect) begin
			rxShift_q <= RX_DATA_RESET;
			rxCount_q <= 4'h0;
			// Synchronous start is already sampled at its sample edge
			rxState_q <= syncSelect ? SCFC_DATA : SCFC_START;
		end else if (rxSampleEn) begin
			case (rxState_q)
				SCFC_START: begin
					// A start bit high at mid-bit was a glitch
					rxState_q <= rxd ? SCFC_IDLE : SCFC_DATA;
				end
				SCFC_DATA: begin
					rxShift_q[rxCount_q] <= rxd;
					rxCount_q <= rxCount_q + 4'h1;
					if (rxCount_q + 4'h1 == nBits) begin
						rxState_q <= parityOn ? SCFC_PARITY : SCFC_STOP;
					end
				end
				SCFC_PARITY: begin
					rxParBit_q <= rxd;
					rxState_q <= SCFC_STOP;
				end
				SCFC_STOP: begin
					rxState_q <= SCFC_IDLE;
				end
				default: begin
					rxState_q <= SCFC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			rxData <= RX_DATA_RESET;
			receiveComplete <= 1'b0;
			frameErrorFlag <= 1'b0;
			parityError <= 1'b0;
		end else if (rxSampleEn && rxState_q == SCFC_STOP) begin
			rxData <= rxShift_q;
			receiveComplete <= 1'b1;
			frameErrorFlag <= ~rxd;
			parityError <= parityOn &&
				(scfc_parity(rxShift_q, nBits, parityOdd) != rxParBit_q);
		end else begin
			receiveComplete <= 1'b0;
		end
	end

endmodule : scfc_core
`default_nettype wire

// ===== verification/scfc_core_checker.sv
// Port assertions for the serial clock and frame core
`timescale 1ns/100ps
`default_nettype none
module scfc_core_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Inputs
	input wire logic [3:0] baudDivisorHigh,
	input wire logic [7:0] baudDivisorLow,
	input wire logic baudDivisorLowWrite,
	input wire logic syncSelect,
	input wire logic transferClockDirection,
	input wire logic [1:0] parityModeField,
	input wire logic txDataWrite,
	// Outputs
	input wire logic txBufferEmpty,
	input wire logic transmitComplete,
	input wire logic receiveComplete,
	input wire logic frameErrorFlag,
	input wire logic parityError,
	input wire logic txd,
	input wire logic transferClockOut,
	input wire logic transferClockOe
);
	logic [12:0] gap_q;
	logic armed_q;
	wire logic master = syncSelect && transferClockDirection;
	wire logic [12:0] period = {1'b0, baudDivisorHigh, baudDivisorLow} + 13'h0001;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// A reload may shift the next edge, so spacing is judged from the edge after it
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= 13'h0000;
			armed_q <= 1'b0;
		end else begin
			gap_q <= $changed(transferClockOut) ? 13'h0001 : gap_q + 13'h0001;
			// An edge launched by a tick in the reload cycle still sits before the restart
			armed_q <= master && !baudDivisorLowWrite &&
				(armed_q || ($changed(transferClockOut) && !$past(baudDivisorLowWrite)));
		end
	end
	clk_spacing_a: assert property (
		master && armed_q && $changed(transferClockOut) |-> gap_q == period)
		else $error("master clock edge spacing wrong");
	master_drive_a: assert property (master [*5] |-> transferClockOe)
		else $error("clock pin not driven in master");
	slave_release_a: assert property (!master [*5] |-> !transferClockOe)
		else $error("clock pin driven outside master");
	clk_quiet_a: assert property (!master [*4] |-> $stable(transferClockOut))
		else $error("clock output moves outside master");
	stop_high_a: assert property ($rose(transmitComplete) |-> txd)
		else $error("line not high after frame");
	tc_pulse_a: assert property (transmitComplete |=> !transmitComplete)
		else $error("transmit complete too long");
	rc_pulse_a: assert property (receiveComplete |=> !receiveComplete)
		else $error("receive complete too long");
	par_off_a: assert property (receiveComplete && !parityModeField[1] |-> !parityError)
		else $error("parity error with parity off");
	write_take_a: assert property (txDataWrite && txBufferEmpty |=> ##1 !txBufferEmpty)
		else $error("write not taken");
	cover property (master && armed_q && $changed(transferClockOut));
	cover property (receiveComplete && frameErrorFlag);
	cover property (receiveComplete && parityError);
	cover property (transmitComplete && syncSelect);
endmodule : scfc_core_checker
bind scfc_core scfc_core_checker i_checker (.core_clk, .resetn, .baudDivisorHigh, .baudDivisorLow,
	.baudDivisorLowWrite, .syncSelect, .transferClockDirection, .parityModeField, .txDataWrite,
	.txBufferEmpty, .transmitComplete, .receiveComplete, .frameErrorFlag, .parityError, .txd,
	.transferClockOut, .transferClockOe);
`default_nettype wire

// ===== verification/scfc_peer.sv
// Far-side serial node model for the asynchronous lines
`timescale 1ns/100ps
`default_nettype none
module scfc_peer (
	// Clock
	input wire logic clk,
	// Lines
	input wire logic lineIn,
	output logic lineOut
);
	initial lineOut = 1'b1;
	task automatic send(input logic [12:0] v, input int nb, input int bc);
		for (int i = 0; i < nb; i++) begin
			lineOut <= v[i];
			repeat (bc) @(negedge clk);
		end
		lineOut <= 1'b1;
	endtask : send
	// Returns at mid last bit so a back-to-back start edge is not missed
	task automatic grab(output logic [12:0] v, input int nb, input int bc, output bit ok);
		int w;
		v = 13'h1fff;
		w = 0;
		while (lineIn !== 1'b0 && w < 4000) begin
			@(negedge clk);
			w++;
		end
		ok = w < 4000;
		repeat (bc / 2) @(negedge clk);
		for (int i = 0; i < nb; i++) begin
			v[i] = lineIn;
			if (i < nb - 1) begin
				repeat (bc) @(negedge clk);
			end
		end
	endtask : grab
endmodule : scfc_peer
`default_nettype wire

// ===== verification/scfc_core_tb.sv
// Self-checking bench for the serial clock and frame core
`timescale 1ns/100ps
`default_nettype none
module scfc_core_tb;
	logic core_clk = 1'b0;
	logic resetn, baudDivisorLowWrite, doubleSpeedSelect, syncSelect, transferClockDirection;
	logic clockPolaritySelect, stopCountSelect, transmitNinthBit, txDataWrite, transferClockIn;
	logic txBufferEmpty, transmitComplete, receiveComplete, frameErrorFlag, parityError;
	logic rxd, txd, transferClockOut, transferClockOe;
	logic [3:0] baudDivisorHigh;
	logic [7:0] baudDivisorLow, txData;
	logic [2:0] characterSizeField;
	logic [1:0] parityModeField;
	logic [8:0] rxData;
	int errorCnt = 0;
	int nCompared = 0;
	always #25 core_clk = ~core_clk;
	scfc_core i_dut (.core_clk, .resetn, .baudDivisorHigh, .baudDivisorLow, .baudDivisorLowWrite,
		.doubleSpeedSelect, .syncSelect, .transferClockDirection, .clockPolaritySelect,
		.characterSizeField, .parityModeField, .stopCountSelect, .txData, .transmitNinthBit,
		.txDataWrite, .txBufferEmpty, .transmitComplete, .rxData, .receiveComplete,
		.frameErrorFlag, .parityError, .rxd, .txd, .transferClockIn, .transferClockOut,
		.transferClockOe);
	scfc_peer i_peer (.clk(core_clk), .lineIn(txd), .lineOut(rxd));
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [12:0] got, input logic [12:0] exp);
		nCompared++;
		if (got !== exp) begin
			errorCnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic await(ref logic s, input int lim);
		int w;
		w = 0;
		while (s !== 1'b1 && w < lim) begin
			@(negedge core_clk);
			w++;
		end
		if (w == lim) begin
			errorCnt++;
			$display("Error at %0t: wait ran out, got %h expected %h", $time, s, 1'b1);
			tally_and_finish();
		end
	endtask : await
	task automatic grabChk(input logic [12:0] e, input int nb, input int bc);
		logic [12:0] g;
		bit ok;
		i_peer.grab(g, nb, bc, ok);
		if (!ok) begin
			errorCnt++;
			$display("Error at %0t: no frame, got %h expected %h", $time, g, e);
			tally_and_finish();
		end
		check(g, e);
	endtask : grabChk
	// Frame as sent on the line, bit 0 first; unused upper bits read as idle high
	function automatic logic [12:0] frame(input logic [8:0] d, input int n, input logic [1:0] pm,
			input logic s2, output int nb);
		logic p;
		logic [12:0] v;
		p = pm[0];
		v = 13'h1fff;
		v[0] = 1'b0;
		for (int i = 0; i < n; i++) begin
			p = p ^ d[i];
			v[i + 1] = d[i];
		end
		nb = n + 2 + int'(s2);
		if (pm[1]) begin
			v[n + 1] = p;
			nb++;
		end
		return v;
	endfunction : frame
	// Both directions share one format; changed only after traffic has ended
	task automatic setcfg(input logic sy, dr, db, input logic [2:0] sz, input logic [1:0] pm,
			input logic s2, input logic [11:0] dv);
		syncSelect = sy;
		transferClockDirection = dr;
		doubleSpeedSelect = db;
		characterSizeField = sz;
		parityModeField = pm;
		stopCountSelect = s2;
		{baudDivisorHigh, baudDivisorLow} = dv;
		baudDivisorLowWrite = 1'b1;
		@(negedge core_clk);
		baudDivisorLowWrite = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : setcfg
	task automatic put(input logic [8:0] d);
		{transmitNinthBit, txData} = d;
		txDataWrite = 1'b1;
		@(negedge core_clk);
		txDataWrite = 1'b0;
		// Empty flag lags the buffer by a cycle; polling it earlier sees a stale value
		@(negedge core_clk);
	endtask : put
	initial begin
		logic [12:0] e0, e1, v, hist;
		logic ck, ckPrev;
		logic [8:0] d0, d1;
		logic [2:0] sz;
		logic [1:0] pm, fl;
		logic s2, db;
		int n, nb, bc, dv, w;
		{resetn, baudDivisorLowWrite, doubleSpeedSelect, syncSelect} = 4'h0;
		{transferClockDirection, clockPolaritySelect, stopCountSelect, transmitNinthBit} = 4'h0;
		{txDataWrite, transferClockIn, baudDivisorHigh, baudDivisorLow, txData} = 22'h000000;
		characterSizeField = 3'h0;
		parityModeField = 2'h0;
		void'($urandom(2));
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int it = 0; it < 12; it++) begin
			n = 5 + int'($urandom % 5);
			w = int'($urandom % 3);
			pm = (w == 0) ? 2'h0 : 2'(w + 1);
			s2 = 1'($urandom);
			db = 1'($urandom);
			dv = int'($urandom % 3);
			if (it == 0) begin
				n = 9;
				pm = 2'h3;
				s2 = 1'b1;
			end
			sz = (n == 9) ? 3'h7 : 3'(n - 5);
			setcfg(1'b0, 1'b0, db, sz, pm, s2, 12'(dv));
			bc = (db ? 8 : 16) * (dv + 1);
			d0 = 9'($urandom);
			d1 = 9'($urandom);
			e0 = frame(d0, n, pm, s2, nb);
			e1 = frame(d1, n, pm, s2, nb);
			fork
				begin
					grabChk(e0, nb, bc);
					grabChk(e1, nb, bc);
				end
				begin
					put(d0);
					await(txBufferEmpty, 2000);
					put(d1);
					await(transmitComplete, 9000);
				end
			join
			fl = 2'($urandom);
			v = e0;
			if (pm[1] && fl[0]) begin
				v[n + 1] = ~v[n + 1];
			end
			if (fl[1]) begin
				v[n + 1 + int'(pm[1])] = 1'b0;
			end
			fork
				i_peer.send(v, nb, bc);
				begin
					await(receiveComplete, 2000);
					check(13'(rxData), 13'(d0 & ~(9'h1ff << n)));
					check(13'({frameErrorFlag, parityError}), 13'({fl[1], fl[0] & pm[1]}));
				end
			join
		end
		for (int m = 0; m < 2; m++) begin
			clockPolaritySelect = 1'($urandom);
			setcfg(1'b1, m == 0, 1'b0, 3'h3, 2'h0, 1'b0, 12'h001);
			d0 = 9'($urandom);
			e0 = frame(d0, 8, 2'h0, 1'b0, nb);
			hist = 13'h1fff;
			put(d0);
			ckPrev = (m == 0) ? transferClockOut : transferClockIn;
			w = 0;
			while (transmitComplete !== 1'b1 && w < 600) begin
				@(negedge core_clk);
				w++;
				ck = (m == 0) ? transferClockOut : transferClockIn;
				// Far side samples the line on the edge opposite to the change edge
				if (ck !== ckPrev && ck === clockPolaritySelect) begin
					hist = {txd, hist[12:1]};
				end
				ckPrev = ck;
				if (m == 1 && w % 4 == 0) begin
					transferClockIn = ~transferClockIn;
				end
			end
			check(13'(w < 600), 13'h0001);
			check(13'(hist[12:3]), 13'(e0[9:0]));
			check(13'(transferClockOe), 13'(m == 0));
		end
		tally_and_finish();
	end
endmodule : scfc_core_tb
`default_nettype wire
